// ===== ddrc_core.sv
// DDR2 device command decoder with bank tracking, termination and refresh.
`default_nettype none
module ddrc_core
   import ddrc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ck_link,
   input wire ddrc_pins_t pins,
   output logic term_switch_a,
   output logic term_switch_b,
   output logic term_switch_c,
   output logic term_strobe_comp,
   output logic dll_on,
   output logic [NBANK-1:0] bank_open,
   output logic self_refresh,
   output logic [ROW_W-1:0] refresh_row
);

   // Reset enters the link domain asynchronously and leaves it on a link edge.
   logic [1:0] lrst_sync;
   logic lrst_n;
   always_ff @(posedge ck_link or negedge nrst) begin
      if (!nrst) begin
         lrst_sync <= 2'h0;
      end else begin
         lrst_sync <= {lrst_sync[0], 1'b1};
      end
   end
   assign lrst_n = lrst_sync[1];

   // Link-domain state.
   ddrc_state_t state;
   ddrc_state_t next_state;
   ddrc_cmd_t cmd;
   logic [NBANK-1:0] open;
   logic [NBANK-1:0] ap_fire;
   logic [1:0] rtt_cur;
   logic [1:0] rtt_new;
   logic [4:0] tmod_cnt;
   logic dqsn_dis;
   logic [2:0] al;
   logic [2:0] bl_code;
   logic [2:0] cl;
   logic [2:0] wr_code;
   logic ref_tgl;
   logic [4:0] half_bl;
   logic [4:0] rd_ap_dly;
   logic [4:0] wr_ap_dly;
   logic term_en;

   // Command decode; a high chip select hides every other pin.
   always_comb begin
      cmd = CMD_NOP;
      if (!pins.cs_n) begin
         case ({pins.ras_n, pins.cas_n, pins.we_n})
            3'h7: cmd = CMD_NOP;
            3'h3: cmd = CMD_ACT;
            3'h5: cmd = CMD_RD;
            3'h4: cmd = CMD_WR;
            3'h2: cmd = CMD_PRE;
            3'h1: cmd = pins.cke ? CMD_REF : CMD_SRE;
            3'h0: cmd = CMD_MRS;
            default: cmd = CMD_OTHER;
         endcase
      end
      // In self-refresh only clock enable is looked at.
      if (state == ST_SREF) begin
         cmd = CMD_NOP;
      end
   end

   // Auto-precharge delays from the latched mode fields.
   always_comb begin
      half_bl = (bl_code == BL8_CODE) ? 5'h4 : 5'h2;
      // Read waits AL plus BL/2, stretched only if tRTP is longer.
      rd_ap_dly = 5'(al) + ((half_bl > TRTP_CYC) ? half_bl : TRTP_CYC);
      // Write waits WL plus BL/2 plus write recovery, WL being AL plus CL less one.
      wr_ap_dly = 5'(al) + 5'(cl) - 5'h1 + half_bl + 5'(wr_code) + 5'h1;
   end

   // Self-refresh state machine.
   always_comb begin
      next_state = state;
      case (state)
         ST_ACTIVE: begin
            if (cmd == CMD_SRE) begin
               next_state = ST_SREF;
            end
         end
         ST_SREF: begin
            if (pins.cke) begin
               next_state = ST_ACTIVE;
            end
         end
         default: next_state = ST_ACTIVE;
      endcase
   end

   always_ff @(posedge ck_link or negedge lrst_n) begin
      if (!lrst_n) begin
         state <= ST_ACTIVE;
      end else begin
         state <= next_state;
      end
   end

   // The delay-locked loop stops for self-refresh and restarts on exit.
   always_ff @(posedge ck_link or negedge lrst_n) begin
      if (!lrst_n) begin
         dll_on <= 1'b1;
      end else begin
         dll_on <= (next_state == ST_ACTIVE);
      end
   end

   // Mode fields; the termination value waits out the update delay.
   always_ff @(posedge ck_link or negedge lrst_n) begin
      if (!lrst_n) begin
         al <= AL_RST;
         bl_code <= BL_RST;
         cl <= CL_RST;
         wr_code <= WR_RST;
         dqsn_dis <= DQSN_DIS_RST;
         rtt_new <= RTT_RST;
      end else if (cmd == CMD_MRS && pins.ba == BA_MR) begin
         bl_code <= pins.addr[BL_LSB +: 3];
         cl <= pins.addr[CL_LSB +: 3];
         wr_code <= pins.addr[WR_LSB +: 3];
      end else if (cmd == CMD_MRS && pins.ba == BA_EMR1) begin
         al <= pins.addr[AL_LSB +: 3];
         dqsn_dis <= pins.addr[DQSN_DIS_BIT];
         rtt_new <= {pins.addr[RTT_HI_BIT], pins.addr[RTT_LO_BIT]};
      end
   end

   // The new value takes effect TMOD_CYC clocks after the command.
   always_ff @(posedge ck_link or negedge lrst_n) begin
      if (!lrst_n) begin
         tmod_cnt <= 5'h0;
         rtt_cur <= RTT_RST;
      end else if (cmd == CMD_MRS && pins.ba == BA_EMR1) begin
         tmod_cnt <= TMOD_CYC;
      end else if (tmod_cnt != 5'h0) begin
         tmod_cnt <= tmod_cnt - 5'h1;
         if (tmod_cnt == 5'h1) begin
            rtt_cur <= rtt_new;
         end
      end
   end

   // Termination follows the pin but never in self-refresh.
   assign term_en = pins.odt && (next_state == ST_ACTIVE);
   always_ff @(posedge ck_link or negedge lrst_n) begin
      if (!lrst_n) begin
         term_switch_a <= 1'b0;
         term_switch_b <= 1'b0;
         term_switch_c <= 1'b0;
         term_strobe_comp <= 1'b0;
      end else begin
         term_switch_a <= term_en && (rtt_cur == RTT_A);
         term_switch_b <= term_en && (rtt_cur == RTT_B);
         term_switch_c <= term_en && (rtt_cur == RTT_C);
         term_strobe_comp <= term_en && (rtt_cur != RTT_OFF) && !dqsn_dis;
      end
   end

   // One tracker per bank: open row, tRAS count and pending auto-precharge.
   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      logic [4:0] ras_cnt;
      logic [4:0] ap_cnt;
      logic ap_arm;
      logic hit;
      assign hit = (pins.ba == 3'(b));
      // Closes on the edge the delay ends, but not before tRAS has run out.
      assign ap_fire[b] = ap_arm && ap_cnt <= 5'h1 && ras_cnt <= 5'h1;
      always_ff @(posedge ck_link or negedge lrst_n) begin
         if (!lrst_n) begin
            open[b] <= 1'b0;
            ras_cnt <= 5'h0;
            ap_cnt <= 5'h0;
            ap_arm <= 1'b0;
         end else begin
            if (ras_cnt != 5'h0) begin
               ras_cnt <= ras_cnt - 5'h1;
            end
            if (ap_cnt != 5'h0) begin
               ap_cnt <= ap_cnt - 5'h1;
            end
            if (cmd == CMD_ACT && hit) begin
               open[b] <= 1'b1;
               ras_cnt <= TRAS_CYC;
               ap_arm <= 1'b0;
            end else if ((cmd == CMD_PRE && (pins.addr[AP_BIT] || hit)) ||
                         cmd == CMD_REF || ap_fire[b]) begin
               open[b] <= 1'b0;
               ap_arm <= 1'b0;
            end else if ((cmd == CMD_RD || cmd == CMD_WR) && hit &&
                         pins.addr[AP_BIT] && open[b]) begin
               ap_arm <= 1'b1;
               ap_cnt <= (cmd == CMD_RD) ? rd_ap_dly : wr_ap_dly;
            end
         end
      end
   end

   // Each auto-refresh flips a toggle that the system domain counts.
   always_ff @(posedge ck_link or negedge lrst_n) begin
      if (!lrst_n) begin
         ref_tgl <= 1'b0;
      end else if (cmd == CMD_REF) begin
         ref_tgl <= ~ref_tgl;
      end
   end

   // System domain: two-flop crossings. The bank bits are synchronised
   // one by one, so a reader may see them settle a cycle apart.
   logic [NBANK-1:0] open_s1;
   logic sref_s1;
   logic [2:0] tgl_s;
   logic [10:0] trefi_cnt;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         open_s1 <= '0;
         bank_open <= '0;
         sref_s1 <= 1'b0;
         self_refresh <= 1'b0;
         tgl_s <= 3'h0;
      end else begin
         open_s1 <= open;
         bank_open <= open_s1;
         sref_s1 <= (state == ST_SREF);
         self_refresh <= sref_s1;
         tgl_s <= {tgl_s[1:0], ref_tgl};
      end
   end

   // Row counter advances on each auto-refresh and on each self-refresh tick.
   // The self-refresh timer runs on the system clock since the link may stop.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         trefi_cnt <= 11'h0;
         refresh_row <= '0;
      end else begin
         if (!self_refresh) begin
            trefi_cnt <= 11'h0;
         end else if (trefi_cnt == TREFI_CYC - 11'h1) begin
            trefi_cnt <= 11'h0;
         end else begin
            trefi_cnt <= trefi_cnt + 11'h1;
         end
         if (tgl_s[2] != tgl_s[1] ||
             (self_refresh && trefi_cnt == TREFI_CYC - 11'h1)) begin
            refresh_row <= refresh_row + 14'h1;
         end
      end
   end

   // Checks on the link-domain logic.
   default clocking @(posedge ck_link); endclocking
   default disable iff (!lrst_n);

   sequence s_sre;
      cmd == CMD_SRE && state == ST_ACTIVE;
   endsequence
   sequence s_rtt_write;
      cmd == CMD_MRS && pins.ba == BA_EMR1;
   endsequence

   a_term_follows: assert property (
      pins.odt && state == ST_ACTIVE && !pins.cke == 1'b0 && rtt_cur != RTT_OFF
      |=> term_switch_a || term_switch_b || term_switch_c)
      else $error("termination not on with pin high");
   a_strobe_term: assert property (
      term_strobe_comp |-> !dqsn_dis && (term_switch_a || term_switch_b || term_switch_c))
      else $error("strobe termination without enable");
   a_sref_odt_off: assert property (
      s_sre |=> !term_switch_a && !term_switch_b && !term_switch_c && !term_strobe_comp)
      else $error("termination on in self-refresh");
   a_one_switch: assert property (
      $onehot0({term_switch_a, term_switch_b, term_switch_c}))
      else $error("more than one termination switch");
   a_rtt_update: assert property (
      s_rtt_write ##1 cmd != CMD_MRS |=> rtt_cur == $past(rtt_new))
      else $error("termination value not applied");
   a_act_opens: assert property (
      cmd == CMD_ACT |=> open[$past(pins.ba)])
      else $error("activate did not open bank");
   a_pre_all: assert property (
      cmd == CMD_PRE && pins.addr[AP_BIT] |=> open == '0)
      else $error("precharge-all left a bank open");
   a_ref_idle: assert property (
      cmd == CMD_REF |=> open == '0 ##0 ref_tgl != $past(ref_tgl))
      else $error("refresh left a bank open");
   a_nop_keeps: assert property (
      cmd == CMD_NOP && ap_fire == '0 |=> $stable(open))
      else $error("no-operation changed a bank");
   a_sref_dll: assert property (
      s_sre |=> (!dll_on && state == ST_SREF) [*2] or ##1 state == ST_ACTIVE)
      else $error("loop left on in self-refresh");

endmodule // ddrc_core
`default_nettype wire

// ===== ddrc_pkg.sv
// Constants and carriers for the DDR2 command, bank and termination block.
`default_nettype none
package ddrc_pkg;
   // Bank and pin geometry.
   localparam int NBANK = 8;
   localparam int ROW_W = 14;
   // Mode register selects on the bank pins.
   localparam logic [2:0] BA_MR = 3'h0;
   localparam logic [2:0] BA_EMR1 = 3'h1;
   // Field positions on the address pins.
   localparam int AP_BIT = 10;
   localparam int DQSN_DIS_BIT = 10;
   localparam int RTT_HI_BIT = 6;
   localparam int RTT_LO_BIT = 2;
   localparam int AL_LSB = 3;
   localparam int BL_LSB = 0;
   localparam int CL_LSB = 4;
   localparam int WR_LSB = 9;
   // Reset values of the latched mode fields, and the burst-length code for eight.
   localparam logic [1:0] RTT_RST = 2'h0;
   localparam logic [2:0] AL_RST = 3'h0;
   localparam logic [2:0] BL_RST = 3'h2;
   localparam logic [2:0] CL_RST = 3'h3;
   localparam logic [2:0] WR_RST = 3'h1;
   localparam logic DQSN_DIS_RST = 1'b0;
   localparam logic [2:0] BL8_CODE = 3'h3;
   // Termination value codes; zero means no termination.
   localparam logic [1:0] RTT_OFF = 2'h0;
   localparam logic [1:0] RTT_A = 2'h1;
   localparam logic [1:0] RTT_B = 2'h2;
   localparam logic [1:0] RTT_C = 2'h3;
   // Times in picoseconds.
   localparam int MCLK_PS = 4000;
   localparam int LINK_TCK_PS = 160000;
   localparam int TMOD_MIN_PS = 0;
   localparam int TRAS_PS = 45000;
   localparam int TRTP_PS = 7500;
   localparam int TREFI_PS = 7800000;
   // A least time rounds up to whole cycles, never below one.
   function automatic int cyc_up(input int ps, input int per);
      int c;
      c = (ps + per - 1) / per;
      return (c < 1) ? 1 : c;
   endfunction
   localparam logic [4:0] TMOD_CYC = 5'(cyc_up(TMOD_MIN_PS, LINK_TCK_PS));
   localparam logic [4:0] TRAS_CYC = 5'(cyc_up(TRAS_PS, LINK_TCK_PS));
   localparam logic [4:0] TRTP_CYC = 5'(cyc_up(TRTP_PS, LINK_TCK_PS));
   // The refresh period is a longest time and rounds down.
   localparam logic [10:0] TREFI_CYC = 11'(TREFI_PS / MCLK_PS);
   // Pins driven by the memory controller, all on the link clock.
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [2:0] ba;
      logic [ROW_W-1:0] addr;
      logic odt;
   } ddrc_pins_t;
   typedef enum {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
      CMD_REF, CMD_SRE, CMD_MRS, CMD_OTHER
   } ddrc_cmd_t;
   typedef enum {ST_ACTIVE, ST_SREF} ddrc_state_t;
endpackage
`default_nettype wire

// ===== ddrc_ctrl_model.sv
// Memory controller model that drives the command, address and termination pins.
`default_nettype none
module ddrc_ctrl_model
   import ddrc_pkg::*;
#(
   parameter int XSNR_CYC = 4
)
(
   input wire logic ck_link,
   output var ddrc_pins_t pins
);
   timeunit 1ns;
   timeprecision 100ps;

   // Start deselected with the clock enable high, as the device expects out of reset.
   initial begin
      pins = '{cke: 1'b1, cs_n: 1'b1, default: '0};
   end

   // Deselect with fresh random strobes and address each cycle, so a stale command never
   // looks valid.
   task automatic idle(input int n);
      for (int i = 0; i < n; i++) begin
         pins.cs_n = 1'b1;
         {pins.ras_n, pins.cas_n, pins.we_n, pins.ba, pins.addr} = 20'($urandom);
         @(posedge ck_link);
         #1;
      end
   endtask

   // One command, held until the edge that takes it.
   task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] a);
      pins.cs_n = 1'b0;
      {pins.ras_n, pins.cas_n, pins.we_n} = rcw;
      pins.ba = ba;
      pins.addr = a;
      @(posedge ck_link);
      #1;
   endtask

   // Termination pin level.
   task automatic set_odt(input logic v);
      pins.odt = v;
   endtask

   // Termination update: the pin stays low from before the command to past the window.
   task automatic emr1(input logic [13:0] a);
      pins.odt = 1'b0;
      idle(2);
      cmd(3'h0, 3'h1, a);
      idle(2);
   endtask

   // Self-refresh entry with termination already off.
   task automatic sref_enter();
      pins.odt = 1'b0;
      idle(2);
      pins.cke = 1'b0;
      cmd(3'h1, 3'h0, 14'h0);
   endtask

   // Exit, then only deselects for the exit delay, then the extra refresh.
   task automatic sref_exit();
      pins.cke = 1'b1;
      idle(1 + XSNR_CYC);
      cmd(3'h1, 3'h0, 14'h0);
      idle(2);
   endtask
endmodule // ddrc_ctrl_model
`default_nettype wire

// ===== ddrc_core_test.sv
// Self-checking bench for the DDR2 command, bank and termination block.
`default_nettype none
module ddrc_core_test
   import ddrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [2:0] C_ACT = 3'h3, C_RD = 3'h5, C_WR = 3'h4, C_PRE = 3'h2;
   localparam logic [2:0] C_REF = 3'h1, C_NOP = 3'h7, C_MRS = 3'h0;
   logic mclk = 1'b0;
   logic ck_link = 1'b0;
   logic nrst = 1'b0;
   logic link_run = 1'b1;
   ddrc_pins_t pins;
   logic term_switch_a, term_switch_b, term_switch_c, term_strobe_comp, dll_on, self_refresh;
   logic [NBANK-1:0] bank_open;
   logic [ROW_W-1:0] refresh_row;
   logic [7:0] eo = 8'h0;
   logic [3:0] et = 4'h0;
   logic ed = 1'b1;
   logic es = 1'b0;
   logic [13:0] er = 14'h0;
   logic [27:0] q[$];
   logic [27:0] got;
   int fail_count = 0;
   int n_checks = 0;

   always #2 mclk = ~mclk;
   // Link clock with its own phase; it only stops while low, never mid-pulse.
   initial begin
      #37;
      forever begin
         #80;
         if (link_run || ck_link) ck_link = ~ck_link;
      end
   end

   ddrc_core ddrc_core_i(.mclk(mclk), .nrst(nrst), .ck_link(ck_link), .pins(pins),
      .term_switch_a(term_switch_a), .term_switch_b(term_switch_b),
      .term_switch_c(term_switch_c), .term_strobe_comp(term_strobe_comp), .dll_on(dll_on),
      .bank_open(bank_open), .self_refresh(self_refresh), .refresh_row(refresh_row));
   ddrc_ctrl_model ddrc_ctrl_model_i(.ck_link(ck_link), .pins(pins));

   assign got = {bank_open, term_switch_a, term_switch_b, term_switch_c, term_strobe_comp,
      dll_on, self_refresh, refresh_row};

   task automatic cmd(input logic [2:0] r, input logic [2:0] b, input logic [13:0] a);
      ddrc_ctrl_model_i.cmd(r, b, a);
   endtask
   task automatic idle(input int n);
      ddrc_ctrl_model_i.idle(n);
   endtask
   // Record the expected outputs and wake the watcher.
   task automatic note();
      q.push_back({eo, et, ed, es, er});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Run limit: a hang counts as a mismatch and still reaches the verdict.
   initial begin
      #200000;
      $display("[FAIL] run time limit expected done seen running");
      fail_count++;
      results();
   end

   // Watcher: waiting on the queue itself means no note is lost while a look is busy.
   initial begin
      logic [27:0] exp;
      forever begin
         wait (q.size() != 0);
         exp = q.pop_front();
         #20;
         for (int i = 0; i < 8 && got !== exp; i++) @(posedge mclk);
         n_checks++;
         if (got !== exp) begin
            $display("[FAIL] outputs expected %h seen %h", exp, got);
            fail_count++;
         end
      end
   end

   initial begin
      logic [1:0] rtt;
      logic dis;
      void'($urandom(32'h9f1fd7b1));
      repeat (3) @(posedge ck_link);
      repeat (8) @(posedge mclk);
      #1;
      nrst = 1'b1;
      note();
      repeat (3) @(posedge ck_link);
      #1;
      // Open every bank, two cycles apart.
      for (int b = 0; b < NBANK; b++) begin
         cmd(C_ACT, 3'(b), 14'($urandom));
         eo[b] = 1'b1;
         idle(1);
         note();
      end
      idle(2);
      cmd(C_PRE, 3'h3, 14'h0);
      eo[3] = 1'b0;
      idle(1);
      note();
      cmd(C_PRE, 3'($urandom), 14'h0400);
      eo = 8'h0;
      idle(2);
      note();
      // Plain read keeps bank 5 open; read with auto-precharge closes bank 2 two edges on.
      cmd(C_ACT, 3'h5, 14'h0);
      cmd(C_RD, 3'h5, 14'h0155);
      cmd(C_ACT, 3'h2, 14'h1234);
      cmd(C_RD, 3'h2, 14'h0400);
      eo = 8'h24;
      idle(1);
      note();
      idle(1);
      eo[2] = 1'b0;
      note();
      cmd(C_WR, 3'h5, 14'h0400);
      idle(5);
      note();
      idle(1);
      eo = 8'h0;
      note();
      // Additive latency of two stretches the read auto-precharge to four edges.
      ddrc_ctrl_model_i.emr1(14'h0010);
      cmd(C_ACT, 3'h1, 14'h0);
      cmd(C_RD, 3'h1, 14'h0400);
      eo = 8'h02;
      idle(3);
      note();
      idle(1);
      eo = 8'h0;
      note();
      // Burst of eight, latency four and recovery three: write closes after
      // 2+4-1+4+3 = 12 edges, read after 2+4 = 6 edges.
      cmd(C_MRS, 3'h0, 14'h0443);
      cmd(C_ACT, 3'h6, 14'h0);
      cmd(C_WR, 3'h6, 14'h0400);
      eo = 8'h40;
      idle(11);
      note();
      idle(1);
      eo = 8'h0;
      note();
      cmd(C_ACT, 3'h7, 14'h0);
      cmd(C_RD, 3'h7, 14'h0400);
      eo = 8'h80;
      idle(5);
      note();
      idle(1);
      eo = 8'h0;
      note();
      // Every termination code with the complement strobe enabled and disabled.
      for (int k = 0; k < 8; k++) begin
         {dis, rtt} = 3'(k);
         ddrc_ctrl_model_i.emr1({3'h0, dis, 3'h0, rtt[1], 3'h0, rtt[0], 2'h0});
         ddrc_ctrl_model_i.set_odt(1'b1);
         idle(2);
         et = {rtt == 2'h1, rtt == 2'h2, rtt == 2'h3, rtt != 2'h0 && !dis};
         note();
         ddrc_ctrl_model_i.set_odt(1'b0);
         idle(2);
         et = 4'h0;
         note();
      end
      cmd(C_ACT, 3'h0, 14'h0);
      cmd(C_NOP, 3'($urandom), 14'($urandom));
      eo = 8'h01;
      idle(1);
      note();
      cmd(C_REF, 3'h0, 14'h0);
      eo = 8'h0;
      er = er + 14'h1;
      idle(2);
      note();
      ddrc_ctrl_model_i.sref_enter();
      cmd(C_ACT, 3'h4, 14'h0);
      ed = 1'b0;
      es = 1'b1;
      note();
      link_run = 1'b0;
      repeat (2 * int'(TREFI_CYC) + 40) @(posedge mclk);
      er = er + 14'h2;
      note();
      link_run = 1'b1;
      repeat (4) @(posedge ck_link);
      #1;
      ddrc_ctrl_model_i.sref_exit();
      ed = 1'b1;
      es = 1'b0;
      er = er + 14'h1;
      note();
      idle(1);
      results();
   end
endmodule // ddrc_core_test
`default_nettype wire
